// ===== avp_lane.sv
// Purpose: synchronise one bit clock, frame enable and data pin; find edges and length
// Assumes: bit clock well below half of core_clk
// Notes:   length counts bit clock falling edges seen while the enable is high
module avp_lane (
  input  wire logic              core_clk,
  input  wire logic              rstn,
  input  wire logic              bclk_pin,
  input  wire logic              fe_pin,
  input  wire logic              data_pin,
  output avp_pkg::avp_lane_s     lane
);

  typedef struct packed {
    logic [2:0] bclk_s;
    logic [2:0] fe_s;
    logic [1:0] dat_s;
    logic [3:0] fcnt;
  } avp_lane_state_s;

  avp_lane_state_s q, d;

  always_comb begin
    d = q;
    d.bclk_s = {q.bclk_s[1:0], bclk_pin};
    d.fe_s   = {q.fe_s[1:0], fe_pin};
    d.dat_s  = {q.dat_s[0], data_pin};
    if (lane.fe_fall) begin
      d.fcnt = 4'h0;
    end else if (lane.bclk_fall && lane.fe && q.fcnt != 4'hf) begin
      d.fcnt = q.fcnt + 4'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  always_comb begin
    lane.bclk_rise  = q.bclk_s[1] & ~q.bclk_s[2];
    lane.bclk_fall  = ~q.bclk_s[1] & q.bclk_s[2];
    lane.fe         = q.fe_s[1];
    lane.fe_rise    = q.fe_s[1] & ~q.fe_s[2];
    lane.fe_fall    = ~q.fe_s[1] & q.fe_s[2];
    lane.data       = q.dat_s[1];
    lane.long_frame = q.fe_s[1] & (q.fcnt >= avp_pkg::LONG_FALLS);
    lane.len        = q.fcnt;
  end

endmodule // avp_lane

// ===== avp_lane_model.sv
// Purpose: far-side model of one serial lane: bit clock, frame enable, data
// Assumes: called just after a core_clk rising edge; half bit period is 4 core cycles
// Notes:   bit clock runs ten cycles a frame, then rests low until the next frame
module avp_lane_model (
  input  wire logic core_clk,
  output logic      bclk,
  output logic      fe,
  output logic      data
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    bclk = 1'b0;
    fe   = 1'b0;
    data = 1'b0;
  end

  // one frame, enable held for len bit clocks, msb first, changes on bit clock rise
  task automatic frame(input logic [3:0] len, input logic [7:0] w);
    int i;
    fe   <= 1'b1;
    data <= w[7];
    repeat (4) @(posedge core_clk);
    // clock runs on past the enable so a cut word can finish
    for (i = 0; i < 10; i++) begin
      bclk <= 1'b1;
      if (i == len) begin
        fe   <= 1'b0;
        // released line shows the inverse of its last bit
        data <= ~data;
      end else if (i > 0 && i < len) begin
        data <= w[7-i];
      end
      repeat (4) @(posedge core_clk);
      bclk <= 1'b0;
      repeat (4) @(posedge core_clk);
    end
    repeat (8) @(posedge core_clk);
  endtask
endmodule // avp_lane_model

// ===== avp_pkg.sv
// Purpose: shared constants, carriers and decoders for the voice serial port
// Assumes: 8-bit left-justified words, msb first on the serial lines
// Notes:   rate codes are internal; lengths are counted in bit clock cycles
package avp_pkg;

  localparam int unsigned WORD_W = 8;
  localparam int unsigned LEN_W  = 4;
  localparam int unsigned LIN_W  = 13;
  localparam int unsigned DLY_FRAMES = 4;

  // coding rates
  localparam logic [1:0] RATE_16K = 2'h0;
  localparam logic [1:0] RATE_24K = 2'h1;
  localparam logic [1:0] RATE_32K = 2'h2;
  localparam logic [1:0] RATE_64K = 2'h3;

  // frame enable lengths in bit clock cycles
  localparam logic [3:0] LEN_16K = 4'h2;
  localparam logic [3:0] LEN_24K = 4'h3;
  localparam logic [3:0] LEN_32K = 4'h4;
  localparam logic [3:0] LEN_64K = 4'h8;
  localparam logic [3:0] LONG_FALLS = 4'h2;

  // frame enable pulses seen before the output may leave high impedance
  localparam logic [1:0] PU_FRAMES = 2'h2;

  // field positions
  localparam int unsigned RXA_TRIM_LSB = 0;
  localparam int unsigned RXA_FILT_BYP = 4;
  localparam int unsigned RXA_MAIN_PD  = 5;
  localparam int unsigned RXA_AUX_PD   = 6;
  localparam int unsigned ST_LSB       = 4;
  localparam int unsigned TDR_DLY_SEL  = 5;

  // receive digital gain, unsigned with five fraction bits
  localparam logic [7:0] GAIN_UNITY = 8'h20;
  localparam int unsigned GAIN_FRAC = 5;
  localparam logic [2:0] ST_MUTE = 3'h7;

  typedef struct packed {
    logic       ok;
    logic [1:0] code;
  } avp_rate_s;

  typedef struct packed {
    logic       bclk_rise;
    logic       bclk_fall;
    logic       fe;
    logic       fe_rise;
    logic       fe_fall;
    logic       data;
    logic       long_frame;
    logic [3:0] len;
  } avp_lane_s;

  typedef struct packed {
    logic [7:0] word;
    logic [1:0] rate;
  } avp_word_s;

  typedef enum logic [2:0] {
    TX_IDLE  = 3'b001,
    TX_DRIVE = 3'b010,
    TX_COUNT = 3'b100
  } avp_tx_e;

  function automatic avp_rate_s len_to_rate(input logic [3:0] len);
    avp_rate_s r;
    r = '{ok: 1'b1, code: RATE_16K};
    case (len)
      LEN_16K: r.code = RATE_16K;
      LEN_24K: r.code = RATE_24K;
      LEN_32K: r.code = RATE_32K;
      LEN_64K: r.code = RATE_64K;
      default: r.ok = 1'b0;
    endcase
    return r;
  endfunction

  function automatic logic [3:0] rate_to_len(input logic [1:0] code);
    logic [3:0] l;
    case (code)
      RATE_16K: l = LEN_16K;
      RATE_24K: l = LEN_24K;
      RATE_32K: l = LEN_32K;
      default:  l = LEN_64K;
    endcase
    return l;
  endfunction

  // sidetone attenuation in half decibels; code 7 is muted
  function automatic logic [7:0] st_att_half_db(input logic [2:0] code);
    logic [7:0] a;
    case (code)
      3'h0:    a = 8'h11;
      3'h1:    a = 8'h15;
      3'h2:    a = 8'h18;
      3'h3:    a = 8'h1b;
      3'h4:    a = 8'h1e;
      3'h5:    a = 8'h24;
      3'h6:    a = 8'h2b;
      default: a = 8'h8c;
    endcase
    return a;
  endfunction

endpackage

// ===== avp_voice_port.sv
// Purpose: serial voice word port with receive path control settings
// Assumes: processing engine answers encode and decode requests within a frame
// Notes:   all serial input pins are asynchronous and pass two flip-flops in avp_lane
// Overview of operation
// - one encode and one decode request per frame period
// - transmit enable length chooses the encode rate of that frame
// - word computed next frame, shifted out two frames after capture
// - delay select adds four frames to the rate request, six in total
// - only rate information is delayed, never the sample word
// - short enable: keep output driven word length minus half bit clock
// - receive words shifted in from data pin by bit clock and enable
// - receive enable length chooses the decode rate
// - receive rate re-evaluated independently every frame
// - complete receive word raises a decode request to the engine
// - sync adjustment applied on decode unless digital gain is in use
// - 13-bit decoded samples multiplied by 8-bit gain before companding
// - latest decoded 8-bit sample readable as decoded word
// - analog control bit 4 bypasses receive smoothing filter
// - analog control bits 2:0 set receive attenuation 0 to 7 dB
// - analog control bit 5 powers down main output amplifier pair
// - analog control bit 6 powers down auxiliary output amplifier pair
// - sidetone bits 6:4 pick one of eight gains down to mute
// - enable high over two bit clock falls means long frame timing
// - output stays high impedance for at least two enable pulses
module avp_voice_port (
  input  wire logic                core_clk,
  input  wire logic                rstn,
  input  wire logic                tx_bit_clock,
  input  wire logic                tx_frame_enable,
  output logic                     tx_serial_out,
  output logic                     tx_serial_oe_n,
  input  wire logic                rx_bit_clock,
  input  wire logic                rx_frame_enable,
  input  wire logic                rx_serial_in,
  input  wire logic [7:0]          tone_and_delay_reg,
  input  wire logic [7:0]          rx_analog_control_reg,
  input  wire logic [7:0]          tx_trim_sidetone_reg,
  input  wire logic [7:0]          rx_digital_gain_reg,
  output logic                     enc_req,
  output logic [1:0]               enc_rate,
  input  wire logic                enc_done,
  input  wire logic [7:0]          enc_word,
  output logic                     dec_req,
  output logic [1:0]               dec_rate,
  output logic [7:0]               dec_word,
  output logic                     dec_sync_adj,
  input  wire logic                dec_lin_valid,
  input  wire logic signed [12:0]  dec_lin,
  output logic [7:0]               decoded_word_reg,
  output logic                     rx_filter_bypass,
  output logic [2:0]               rx_trim_atten,
  output logic                     main_amp_pd,
  output logic                     aux_amp_pd,
  output logic [2:0]               sidetone_sel,
  output logic [7:0]               sidetone_att_half_db,
  output logic                     sidetone_mute,
  output logic                     long_frame
);

  localparam int unsigned DLY = avp_pkg::DLY_FRAMES;

  typedef struct packed {
    avp_pkg::avp_tx_e              tx_st;
    logic [2:0]                    idx;
    logic                          seen_rise;
    logic [3:0]                    fcnt;
    logic [1:0]                    pu_cnt;
    avp_pkg::avp_word_s            out_w;
    avp_pkg::avp_word_s            nxt_w;
    logic                          nxt_vld;
    avp_pkg::avp_rate_s            req_pend;
    avp_pkg::avp_rate_s [DLY-1:0]  pipe;
    logic                          enc_req;
    logic [1:0]                    enc_rate;
    logic                          txd;
    logic                          oe_n;
    logic                          long_frame;
    logic [7:0]                    rx_sh;
    logic                          dec_req;
    logic [1:0]                    dec_rate;
    logic [7:0]                    dec_word;
    logic                          sync_adj;
    logic [7:0]                    dec_out;
    logic                          filt_byp;
    logic [2:0]                    trim;
    logic                          main_pd;
    logic                          aux_pd;
    logic [2:0]                    st_sel;
    logic [7:0]                    st_att;
  } avp_core_s;

  avp_core_s           q, d;
  avp_pkg::avp_lane_s  tx_l, rx_l;
  avp_pkg::avp_rate_s  tx_cap, rx_cap;
  logic                dly_sel, gain_used;
  logic [3:0]          wlen;

  avp_lane u_tx_lane (
    .core_clk (core_clk),
    .rstn     (rstn),
    .bclk_pin (tx_bit_clock),
    .fe_pin   (tx_frame_enable),
    .data_pin (1'b0),
    .lane     (tx_l)
  );

  avp_lane u_rx_lane (
    .core_clk (core_clk),
    .rstn     (rstn),
    .bclk_pin (rx_bit_clock),
    .fe_pin   (rx_frame_enable),
    .data_pin (rx_serial_in),
    .lane     (rx_l)
  );

  // signed gain multiply, five fraction bits, saturated to 13 bits
  function automatic logic signed [12:0] scale(input logic signed [12:0] s,
                                               input logic [7:0] g);
    logic signed [21:0] p;
    logic signed [21:0] sh;
    p  = 22'(s) * $signed({14'h0, g});
    sh = p >>> avp_pkg::GAIN_FRAC;
    if (sh > 22'sh000fff) begin
      return 13'sh0fff;
    end else if (sh < -22'sh001000) begin
      return -13'sh1000;
    end
    return sh[12:0];
  endfunction

  // segment companding of 13-bit linear, positive sign bit set, bits inverted
  function automatic logic [7:0] compand(input logic signed [12:0] s);
    logic [12:0] mag;
    logic [12:0] m;
    logic [2:0]  ch;
    logic [3:0]  stp;
    mag = s[12] ? 13'(-s) : 13'(s);
    m   = (mag > 13'h1fde) ? 13'h1fff : mag + 13'h21;
    ch  = 3'h0;
    for (int i = 1; i < 8; i++) begin
      if (m[i+5]) begin
        ch = 3'(i);
      end
    end
    stp = 4'(m >> ({1'b0, ch} + 4'h1));
    return {~s[12], ~ch, ~stp};
  endfunction

  always_comb begin
    dly_sel   = tone_and_delay_reg[avp_pkg::TDR_DLY_SEL];
    gain_used = (rx_digital_gain_reg != avp_pkg::GAIN_UNITY);
    tx_cap    = avp_pkg::len_to_rate(tx_l.len);
    rx_cap    = avp_pkg::len_to_rate(rx_l.len);
    wlen      = avp_pkg::rate_to_len(q.out_w.rate);
  end

  always_comb begin
    d = q;
    d.enc_req = 1'b0;
    d.dec_req = 1'b0;
    d.long_frame = tx_l.long_frame;

    // control settings
    d.filt_byp = rx_analog_control_reg[avp_pkg::RXA_FILT_BYP];
    d.trim     = rx_analog_control_reg[avp_pkg::RXA_TRIM_LSB +: 3];
    d.main_pd  = rx_analog_control_reg[avp_pkg::RXA_MAIN_PD];
    d.aux_pd   = rx_analog_control_reg[avp_pkg::RXA_AUX_PD];
    d.st_sel   = tx_trim_sidetone_reg[avp_pkg::ST_LSB +: 3];
    d.st_att   = avp_pkg::st_att_half_db(d.st_sel);

    // transmit rate capture at end of enable
    if (tx_l.fe_fall) begin
      if (q.pu_cnt != avp_pkg::PU_FRAMES) begin
        d.pu_cnt = q.pu_cnt + 2'h1;
      end
      d.pipe     = {q.pipe[DLY-2:0], tx_cap};
      d.req_pend = dly_sel ? q.pipe[DLY-1] : tx_cap;
    end

    // request issued in the frame after capture; previous result goes out now
    if (tx_l.fe_rise) begin
      d.enc_req     = q.req_pend.ok;
      d.enc_rate    = q.req_pend.code;
      d.req_pend.ok = 1'b0;
      d.nxt_vld     = 1'b0;
    end
    if (enc_done) begin
      d.nxt_w   = '{word: enc_word, rate: q.enc_rate};
      d.nxt_vld = 1'b1;
    end

    // output driver
    if (tx_l.fe_rise) begin
      d.tx_st = avp_pkg::TX_IDLE;
      if (q.pu_cnt == avp_pkg::PU_FRAMES && q.nxt_vld) begin
        d.tx_st     = avp_pkg::TX_DRIVE;
        d.out_w     = q.nxt_w;
        d.idx       = 3'h0;
        d.seen_rise = 1'b0;
        d.fcnt      = 4'h0;
        d.txd       = q.nxt_w.word[7];
      end
    end else begin
      case (q.tx_st)
        avp_pkg::TX_IDLE: begin
          d.txd = 1'b0;
        end
        avp_pkg::TX_DRIVE, avp_pkg::TX_COUNT: begin
          if (tx_l.bclk_rise) begin
            d.seen_rise = 1'b1;
            if (q.seen_rise && q.idx != 3'h7) begin
              d.idx = q.idx + 3'h1;
            end
            d.txd = q.out_w.word[3'h7 - d.idx];
          end
          if (tx_l.bclk_fall && q.fcnt != 4'hf) begin
            d.fcnt = q.fcnt + 4'h1;
          end
          if (q.tx_st == avp_pkg::TX_DRIVE && tx_l.fe_fall) begin
            d.tx_st = (d.fcnt >= wlen) ? avp_pkg::TX_IDLE : avp_pkg::TX_COUNT;
          end else if (q.tx_st == avp_pkg::TX_COUNT && d.fcnt >= wlen) begin
            d.tx_st = avp_pkg::TX_IDLE;
          end
        end
        default: begin
          d.tx_st = avp_pkg::TX_IDLE;
        end
      endcase
    end
    d.oe_n = (d.tx_st == avp_pkg::TX_IDLE);

    // receive capture, one request per frame
    if (rx_l.bclk_fall && rx_l.fe) begin
      d.rx_sh = {q.rx_sh[6:0], rx_l.data};
    end
    if (rx_l.fe_fall && rx_cap.ok) begin
      d.dec_req  = 1'b1;
      d.dec_rate = rx_cap.code;
      d.dec_word = 8'(q.rx_sh << (4'h8 - rx_l.len));
      d.sync_adj = ~gain_used;
    end
    if (dec_lin_valid) begin
      d.dec_out = compand(gain_used ? scale(dec_lin, rx_digital_gain_reg) : dec_lin);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      q        <= '0;
      q.tx_st  <= avp_pkg::TX_IDLE;
      q.oe_n   <= 1'b1;
      q.dec_out <= 8'hff;
    end else begin
      q <= d;
    end
  end

  assign tx_serial_out        = q.txd;
  assign tx_serial_oe_n       = q.oe_n;
  assign enc_req              = q.enc_req;
  assign enc_rate             = q.enc_rate;
  assign dec_req              = q.dec_req;
  assign dec_rate             = q.dec_rate;
  assign dec_word             = q.dec_word;
  assign dec_sync_adj         = q.sync_adj;
  assign decoded_word_reg     = q.dec_out;
  assign rx_filter_bypass     = q.filt_byp;
  assign rx_trim_atten        = q.trim;
  assign main_amp_pd          = q.main_pd;
  assign aux_amp_pd           = q.aux_pd;
  assign sidetone_sel         = q.st_sel;
  assign sidetone_att_half_db = q.st_att;
  assign sidetone_mute        = (q.st_sel == avp_pkg::ST_MUTE);
  assign long_frame           = q.long_frame;

  // helpers for checks
  logic       tx_rise_h, tx_fall_h, rx_fall_h, rx_bfall_h, rx_fe_h, rx_dat_h, tx_fe_h;
  logic [3:0] rx_len_h;
  logic       nxt_msb_h, pu_ok_h;
  avp_pkg::avp_rate_s pipe_last_h, pend_h;
  always_comb begin
    tx_rise_h   = tx_l.fe_rise;
    tx_fall_h   = tx_l.fe_fall;
    tx_fe_h     = tx_l.fe;
    rx_fall_h   = rx_l.fe_fall;
    rx_bfall_h  = rx_l.bclk_fall;
    rx_fe_h     = rx_l.fe;
    rx_dat_h    = rx_l.data;
    rx_len_h    = rx_l.len;
    nxt_msb_h   = q.nxt_w.word[7];
    pu_ok_h     = (q.pu_cnt == avp_pkg::PU_FRAMES) && q.nxt_vld;
    pipe_last_h = q.pipe[DLY-1];
    pend_h      = q.req_pend;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  a_enc_frame_start: assert property (enc_req |-> $past(tx_rise_h))
    else $error("encode request outside frame start");
  a_word_out_start: assert property (tx_rise_h && pu_ok_h |=>
    !tx_serial_oe_n && tx_serial_out == $past(nxt_msb_h))
    else $error("prepared word not driven at frame start");
  a_tx_rate_map: assert property (tx_fall_h && !dly_sel && tx_l.len == avp_pkg::LEN_64K |=>
    pend_h.ok && pend_h.code == avp_pkg::RATE_64K)
    else $error("transmit length not decoded");
  a_delay_pipe: assert property (tx_fall_h && dly_sel |=> pend_h == $past(pipe_last_h))
    else $error("delayed rate request wrong");
  a_hold_len: assert property ($rose(tx_serial_oe_n) && !$past(tx_fe_h) |->
    q.fcnt >= wlen)
    else $error("output released before word end");
  a_powerup_hiz: assert property (q.pu_cnt != avp_pkg::PU_FRAMES |-> ##1 tx_serial_oe_n)
    else $error("output driven too early");
  a_rx_shift_in: assert property (rx_bfall_h && rx_fe_h |=> q.rx_sh[0] == $past(rx_dat_h))
    else $error("receive bit not captured");
  a_dec_rate_map: assert property (rx_fall_h && rx_len_h == avp_pkg::LEN_32K |=>
    dec_req && dec_rate == avp_pkg::RATE_32K)
    else $error("receive length not decoded");
  a_dec_req_end: assert property (dec_req |-> $past(rx_fall_h) ##1 !dec_req)
    else $error("decode request not a single pulse at frame end");
  a_sync_skip: assert property (dec_req |->
    dec_sync_adj == ($past(rx_digital_gain_reg) == avp_pkg::GAIN_UNITY))
    else $error("sync adjustment wrong");
  a_gain_zero: assert property (dec_lin_valid && rx_digital_gain_reg == 8'h00 |=>
    decoded_word_reg == 8'hff)
    else $error("zero gain not applied");
  a_decoded_zero: assert property (dec_lin_valid && !gain_used && dec_lin == 13'sh0000 |=>
    decoded_word_reg == 8'hff)
    else $error("decoded word wrong");
  a_rx_analog: assert property (##1 {main_amp_pd, aux_amp_pd, rx_filter_bypass, rx_trim_atten} ==
    {$past(rx_analog_control_reg[5]), $past(rx_analog_control_reg[6]),
     $past(rx_analog_control_reg[4]), $past(rx_analog_control_reg[2:0])})
    else $error("analog controls not applied");
  a_sidetone: assert property (##1 sidetone_sel == $past(tx_trim_sidetone_reg[6:4]) &&
    sidetone_mute == (sidetone_sel == 3'h7))
    else $error("sidetone select wrong");
  a_long_flag: assert property (long_frame |-> $past(tx_fe_h))
    else $error("long frame flag without enable");

  c_short_count: cover property (q.tx_st == avp_pkg::TX_DRIVE ##1 q.tx_st == avp_pkg::TX_COUNT);
  c_delayed_req: cover property (dly_sel && enc_req);
  c_dec_16k: cover property (dec_req && dec_rate == avp_pkg::RATE_16K);
  c_long_frame: cover property ($rose(long_frame));

endmodule // avp_voice_port

// ===== avp_voice_port_tb.sv
// Purpose: self-checking bench for the voice serial port
// Assumes: engine answers each encode request one cycle later
// Notes:   expected results are queued by the drivers, checked by the watchers
module avp_voice_port_tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic              core_clk = 1'b0;
  logic              rstn     = 1'b0;
  logic              tx_bclk, tx_fe, tx_d, rx_bclk, rx_fe, rx_d;
  logic [7:0]        tdr = 8'h00, rxa = 8'h00, sto = 8'h00, gain = 8'h20;
  logic              enc_done = 1'b0, lin_v = 1'b0;
  logic [7:0]        enc_word = 8'h00, ew, tw;
  logic signed [12:0] lin = '0;
  logic              tx_out, oe_n, enc_req, dec_req, sync_adj, rfb, mpd, apd, smute, lf;
  logic [1:0]        enc_rate, dec_rate;
  logic [7:0]        dec_word, dwr, satt;
  logic [2:0]        rta, ssel;
  logic [3:0]        lens[4] = '{4'h2, 4'h3, 4'h4, 4'h8};
  logic [7:0]        att[8] = '{8'h11, 8'h15, 8'h18, 8'h1b, 8'h1e, 8'h24, 8'h2b, 8'h8c};
  logic [1:0]        rq[$], hist[$];
  logic [18:0]       dq[$];
  logic [1:0]        rts[4] = '{avp_pkg::RATE_16K, avp_pkg::RATE_24K, avp_pkg::RATE_32K,
                                avp_pkg::RATE_64K};
  logic [9:0]        wq[$];
  logic [9:0]        we;
  logic              lfe;
  logic [18:0]       de;
  int                n_fail = 0, checks = 0, seed = 85295, tn = 0, fl = 0;

  always #25 core_clk = ~core_clk;

  avp_lane_model u_txm (.core_clk(core_clk), .bclk(tx_bclk), .fe(tx_fe), .data(tx_d));
  avp_lane_model u_rxm (.core_clk(core_clk), .bclk(rx_bclk), .fe(rx_fe), .data(rx_d));

  avp_voice_port u_dut (
    .core_clk(core_clk), .rstn(rstn), .tx_bit_clock(tx_bclk), .tx_frame_enable(tx_fe),
    .tx_serial_out(tx_out), .tx_serial_oe_n(oe_n), .rx_bit_clock(rx_bclk),
    .rx_frame_enable(rx_fe), .rx_serial_in(rx_d), .tone_and_delay_reg(tdr),
    .rx_analog_control_reg(rxa), .tx_trim_sidetone_reg(sto), .rx_digital_gain_reg(gain),
    .enc_req(enc_req), .enc_rate(enc_rate), .enc_done(enc_done), .enc_word(enc_word),
    .dec_req(dec_req), .dec_rate(dec_rate), .dec_word(dec_word), .dec_sync_adj(sync_adj),
    .dec_lin_valid(lin_v), .dec_lin(lin), .decoded_word_reg(dwr), .rx_filter_bypass(rfb),
    .rx_trim_atten(rta), .main_amp_pd(mpd), .aux_amp_pd(apd), .sidetone_sel(ssel),
    .sidetone_att_half_db(satt), .sidetone_mute(smute), .long_frame(lf)
  );

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic summarize;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // engine stand-in and request watcher
  always @(posedge core_clk) begin
    enc_done <= (enc_req === 1'b1);
    if (enc_req === 1'b1) begin
      if (rq.size() > 0) chk(8'(enc_rate), 8'(rq.pop_front()), "enc rate");
      else chk(8'h0, 8'h1, "extra enc request");
      ew = 8'($random(seed));
      enc_word <= ew;
      wq.push_back({enc_rate, ew});
    end
    if (dec_req === 1'b1) begin
      if (dq.size() > 0) begin
        de = dq.pop_front();
        chk(8'(dec_rate), 8'(de[18:17]), "dec rate");
        chk(8'(sync_adj), 8'(de[16]), "sync adj");
        chk(dec_word & de[7:0], de[15:8] & de[7:0], "dec word");
      end else chk(8'h0, 8'h1, "extra dec request");
    end
  end

  // serial output watcher, sampled mid low phase of the bit clock
  always @(posedge tx_fe) fl = 0;

  always @(negedge tx_bclk) begin
    lfe = tx_fe;
    if (lfe === 1'b1) fl++;
    repeat (2) @(posedge core_clk);
    chk(8'(lf), 8'(lfe === 1'b1 && fl >= 3), "long frame");
    if (oe_n === 1'b0) begin
      tw = {tw[6:0], tx_out};
      tn++;
    end
  end

  // word ends when the output is released, possibly after the enable fell
  always @(posedge oe_n) begin
    if (tn > 0) begin
      if (wq.size() > 0) begin
        we = wq.pop_front();
        chk(8'(tn), 8'(fl > lens[we[9:8]] ? fl : lens[we[9:8]]), "drive length");
        chk(tw & 8'((9'h1 << tn) - 1), 8'(we[7:0] >> (8 - tn)), "tx word");
      end else chk(8'h0, 8'h1, "early drive");
    end
    tn = 0;
  end

  initial begin
    #2ms;
    n_fail++;
    summarize();
  end

  initial begin
    int i, k;
    logic [3:0] lr;
    repeat (16) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    fork
      for (int a = 0; a < 16; a++) begin
        k = {$random(seed)} % 4;
        hist.push_back(rts[k]);
        rq.push_back(a >= 8 ? hist[a-4] : hist[a]);
        tdr <= {2'h0, a >= 8, 5'h00};
        u_txm.frame(lens[k], 8'($random(seed)));
      end
      for (int b = 0; b < 12; b++) begin
        lr = (b == 5) ? 4'h5 : lens[{$random(seed)} % 4];
        ew = 8'($random(seed));
        gain <= b[0] ? 8'h20 : 8'($random(seed)) | 8'h40;
        if (lr != 4'h5)
          dq.push_back({lr == 4'h2 ? 2'h0 : lr == 4'h3 ? 2'h1 : lr == 4'h4 ? 2'h2 : 2'h3,
                        b[0], ew, 8'hff << (8 - lr)});
        u_rxm.frame(lr, ew);
      end
    join
    gain <= 8'h20;
    for (i = 0; i < 8; i++) begin
      rxa <= 8'($random(seed));
      sto <= {1'b0, 3'(i), 4'($random(seed))};
      repeat (2) @(posedge core_clk);
      chk(8'({rfb, mpd, apd}), 8'({rxa[4], rxa[5], rxa[6]}), "amp ctrl");
      chk(8'(rta), 8'(rxa[2:0]), "trim");
      chk(satt, att[sto[6:4]], "sidetone att");
      chk(8'({ssel, smute}), 8'({sto[6:4], sto[6:4] == 3'h7}), "sidetone sel");
    end
    // negative full scale first, so a stuck register cannot pass
    for (i = 0; i < 3; i++) begin
      gain <= (i == 1) ? 8'h00 : 8'h20;
      lin <= (i == 0) ? 13'h1000 : (i == 1) ? 13'($random(seed)) : 13'h0000;
      @(posedge core_clk);
      lin_v <= 1'b1;
      @(posedge core_clk);
      lin_v <= 1'b0;
      repeat (2) @(posedge core_clk);
      chk(dwr, (i == 0) ? 8'h0f : 8'hff, "decoded word");
    end
    summarize();
  end
endmodule // avp_voice_port_tb
